/* hdl/src_reclock_ctrl.sv */
/*
  control and output selection for a serial video reclocker: rate mode,
  lock qualify, bypass, mute and second-output mode.
  assumes the analog loop reports activity, lock and a measured rate class,
  and the serial streams pass through as sampled levels on ref_clk_i.
*/
// Function
// - retime only at the five supported rates
// - never report lock on a harmonic
// - odd rates stay unlocked, auto bypass
// - rate code 00 auto, 01 SD, 10 HD/3G
// - undriven rate selector reads low
// - DVB-ASI works in SD or auto mode
// - second output select high gives clock
// - undriven second output select reads low
// - mute low silences both outputs
// - mute overrides bypass and lock
// - undriven mute input reads high
// - muted output holds opposite legs
// - bypass with clock mode mutes second output
// - clock invalid on unsupported rate bypass
// - forced bypass passes raw data
// - auto bypass when unlocked or unsupported
// - forced bypass holds lock indicator low
// - undriven bypass input reads low
// - lock only with activity and locked loop
// - mute tied to lock mutes when unlocked
`timescale 1ns/1ps
`include "src_defines.svh"

module src_reclock_ctrl (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  // control pins, undriven pins resolve through board pulls
  input  wire src_pkg::src_ctrl_t ctrl_i,
  // analog loop status
  input  wire src_pkg::src_loop_t loop_i,
  // serial streams
  input  wire logic              serial_in_pair_i,
  input  wire logic              retimed_data_i,
  input  wire logic              recovered_clk_i,
  // outputs
  output logic [1:0]             primary_serial_out_o,
  output logic [1:0]             second_out_clock_or_data_o,
  output logic                   lock_indicator_o,
  output logic                   bypass_active_o,
  output logic                   second_clock_invalid_o,
  // rate mode fed to the loop
  output logic [1:0]             rate_mode_o
);

  // ==========================================
  // synchronised controls
  localparam int CW = $bits(src_pkg::src_ctrl_t);
  // reset value: rate auto, no bypass, unmuted, data mode
  localparam logic [CW-1:0] CTRL_RST = {`SRC_RATE_AUTO, 1'b0, 1'b1, 1'b0};

  src_pkg::src_ctrl_t ctrl_s;
  src_pkg::src_loop_t loop_s;

  src_sync3 #(
    .W       (CW),
    .RST_VAL (CTRL_RST)
  ) u_sync_ctrl (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .async_i   (ctrl_i),
    .sync_o    (ctrl_s)
  );

  src_sync3 #(
    .W       ($bits(src_pkg::src_loop_t)),
    .RST_VAL ('0)
  ) u_sync_loop (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .async_i   (loop_i),
    .sync_o    (loop_s)
  );

  // ==========================================
  // rate acceptance
  function automatic logic rate_ok(input logic [1:0] mode, input logic [2:0] meas);
    logic sd;
    logic hd;
    sd = (meas == `SRC_MEAS_270);
    hd = (meas == `SRC_MEAS_1483) || (meas == `SRC_MEAS_1485) ||
         (meas == `SRC_MEAS_2967) || (meas == `SRC_MEAS_2970);
    unique case (mode)
      `SRC_RATE_AUTO: rate_ok = sd || hd;
      `SRC_RATE_SD:   rate_ok = sd;
      `SRC_RATE_HD:   rate_ok = hd;
      default:        rate_ok = 1'b0;
    endcase
  endfunction : rate_ok

  logic mode_rate_ok;
  assign mode_rate_ok = rate_ok(ctrl_s.rate_sel, loop_s.meas_rate);

  // ==========================================
  // lock qualifier
  src_pkg::src_lock_state_t  lock_st_r;
  logic [`SRC_CNT_W-1:0]     qual_cnt_r;
  logic                      lock_cond;

  // harmonic and odd rate classes never pass rate_ok
  assign lock_cond = loop_s.activity && loop_s.pll_locked && mode_rate_ok
                     && !ctrl_s.bypass_force;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      lock_st_r  <= src_pkg::SRC_UNLOCKED;
      qual_cnt_r <= '0;
    end else begin
      unique case (lock_st_r)
        src_pkg::SRC_UNLOCKED: begin
          qual_cnt_r <= '0;
          if (lock_cond) begin
            lock_st_r <= src_pkg::SRC_QUALIFY;
          end
        end
        src_pkg::SRC_QUALIFY: begin
          if (!lock_cond) begin
            lock_st_r <= src_pkg::SRC_UNLOCKED;
          end else if (qual_cnt_r == `SRC_CNT_W'(`SRC_LOCK_QUAL_CYC - 1)) begin
            lock_st_r <= src_pkg::SRC_LOCKED;
          end else begin
            qual_cnt_r <= qual_cnt_r + `SRC_CNT_W'(1);
          end
        end
        src_pkg::SRC_LOCKED: begin
          if (!lock_cond) begin
            lock_st_r <= src_pkg::SRC_UNLOCKED;
          end
        end
        default: lock_st_r <= src_pkg::SRC_UNLOCKED;
      endcase
    end
  end

  logic locked;
  assign locked = (lock_st_r == src_pkg::SRC_LOCKED) && lock_cond;

  // ==========================================
  // path selection
  logic bypass;
  logic muted;
  logic second_mute;
  logic data_bit;

  assign bypass      = ctrl_s.bypass_force || !locked;
  assign muted       = !ctrl_s.mute_n;
  assign second_mute = muted || (bypass && ctrl_s.second_out_clock_select);
  assign data_bit    = bypass ? serial_in_pair_i : retimed_data_i;

  // ==========================================
  // output registers
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      primary_serial_out_o <= 2'h1;
    end else if (muted) begin
      primary_serial_out_o <= 2'h1;
    end else begin
      primary_serial_out_o <= {data_bit, !data_bit};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      second_out_clock_or_data_o <= 2'h1;
    end else if (second_mute) begin
      second_out_clock_or_data_o <= 2'h1;
    end else if (ctrl_s.second_out_clock_select) begin
      second_out_clock_or_data_o <= {recovered_clk_i, !recovered_clk_i};
    end else begin
      second_out_clock_or_data_o <= {data_bit, !data_bit};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      lock_indicator_o       <= 1'b0;
      bypass_active_o        <= 1'b1;
      second_clock_invalid_o <= 1'b0;
      rate_mode_o            <= `SRC_RATE_AUTO;
    end else begin
      lock_indicator_o       <= locked;
      bypass_active_o        <= bypass;
      // clock unusable when auto bypass runs on an unsupported rate
      second_clock_invalid_o <= ctrl_s.second_out_clock_select && !ctrl_s.bypass_force
                                && !mode_rate_ok;
      rate_mode_o            <= ctrl_s.rate_sel;
    end
  end

endmodule : src_reclock_ctrl

/* hdl/src_defines.svh */
/*
  timing counts and code points for the reclocker control block.
  assumes a 100 MHz ref_clk_i.
*/
`ifndef SRC_DEFINES_SVH
`define SRC_DEFINES_SVH

// ==========================================
// rate selector codes
`define SRC_RATE_AUTO      2'h0
`define SRC_RATE_SD        2'h1
`define SRC_RATE_HD        2'h2
`define SRC_RATE_RSVD      2'h3

// ==========================================
// measured rate classes from the detector
`define SRC_MEAS_NONE      3'h0
`define SRC_MEAS_270       3'h1
`define SRC_MEAS_1483      3'h2
`define SRC_MEAS_1485      3'h3
`define SRC_MEAS_2967      3'h4
`define SRC_MEAS_2970      3'h5
`define SRC_MEAS_OTHER     3'h6
`define SRC_MEAS_HARMONIC  3'h7

// ==========================================
// timing
`define SRC_CLK_PERIOD_NS  10
`define SRC_LOCK_QUAL_NS   320
`define SRC_LOCK_QUAL_CYC  ((`SRC_LOCK_QUAL_NS + `SRC_CLK_PERIOD_NS - 1) / `SRC_CLK_PERIOD_NS)
`define SRC_CNT_W          6

`endif

/* hdl/src_pkg.sv */
/*
  types for the reclocker control block.
  assumes src_defines.svh is on the include path.
*/
package src_pkg;

  // ==========================================
  // controls from the pins
  typedef struct packed {
    logic [1:0] rate_sel;
    logic       bypass_force;
    logic       mute_n;
    logic       second_out_clock_select;
  } src_ctrl_t;

  // ==========================================
  // status from the analog loop
  typedef struct packed {
    logic       activity;
    logic       pll_locked;
    logic [2:0] meas_rate;
  } src_loop_t;

  // ==========================================
  // lock qualifier states
  typedef enum logic [1:0] {
    SRC_UNLOCKED,
    SRC_QUALIFY,
    SRC_LOCKED
  } src_lock_state_t;

endpackage : src_pkg

/* hdl/src_sync3.sv */
/*
  three-stage synchroniser with agreement filter for a bundle of pin levels.
  assumes one clock; reset value given as a parameter.
*/
`timescale 1ns/1ps

module src_sync3 #(
  parameter int         W         = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         nrst_i,
  // levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
          sync_o[g] <= RST_VAL[g];
        end else if (s2_r[g] == s3_r[g]) begin
          sync_o[g] <= s3_r[g];
        end
      end
    end
  endgenerate

endmodule : src_sync3

/* bench/src_ctrl_monitor.sv */
/*
  checker for the reclock control block outputs.
  assumes it is bound to src_reclock_ctrl and sees its ports only.
*/
`timescale 1ns/1ps

module src_ctrl_monitor (
  input wire logic               ref_clk_i,
  input wire logic               nrst_i,
  input wire src_pkg::src_ctrl_t ctrl_i,
  input wire src_pkg::src_loop_t loop_i,
  input wire logic [1:0]         primary_serial_out_o,
  input wire logic [1:0]         second_out_clock_or_data_o,
  input wire logic               lock_indicator_o,
  input wire logic               bypass_active_o,
  input wire logic [1:0]         rate_mode_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // ========================================
  // output relations
  a_legs_apart: assert property (^primary_serial_out_o && ^second_out_clock_or_data_o)
    else $error("output legs equal");
  a_mute_both: assert property (!ctrl_i.mute_n [*8] |->
    primary_serial_out_o == 2'h1 && second_out_clock_or_data_o == 2'h1) else $error("mute ignored");
  a_force_unlock: assert property (ctrl_i.bypass_force [*8] |-> !lock_indicator_o && bypass_active_o)
    else $error("lock under forced bypass");
  a_lock_retime: assert property (lock_indicator_o |-> !bypass_active_o)
    else $error("bypass while locked");
  a_lock_cause: assert property (lock_indicator_o |->
    $past(loop_i.activity, 10) && $past(loop_i.pll_locked, 10)) else $error("lock without loop");
  a_no_harmonic: assert property (lock_indicator_o |-> $past(loop_i.meas_rate, 10) inside {[3'h1:3'h5]})
    else $error("lock on bad rate");
  a_clk_bypass_mute: assert property (ctrl_i.second_out_clock_select [*8] ##0 bypass_active_o |->
    second_out_clock_or_data_o == 2'h1) else $error("clock not muted");
  a_rate_code: assert property ($stable(ctrl_i.rate_sel) [*8] |-> rate_mode_o == ctrl_i.rate_sel)
    else $error("rate code wrong");
endmodule : src_ctrl_monitor

bind src_reclock_ctrl src_ctrl_monitor u_mon (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ctrl_i(ctrl_i),
  .loop_i(loop_i), .primary_serial_out_o(primary_serial_out_o), .rate_mode_o(rate_mode_o),
  .second_out_clock_or_data_o(second_out_clock_or_data_o), .lock_indicator_o(lock_indicator_o),
  .bypass_active_o(bypass_active_o));

/* bench/src_far_model.sv */
/*
  far-side model: raw stream, retimed bits and recovered clock.
  assumes one reference clock from the bench.
*/
`timescale 1ns/1ps

module src_far_model (
  // clock
  input  wire logic ref_clk_i,
  // streams
  output logic      raw_o,
  output logic      ret_o,
  output logic      rclk_o
);
  logic raw_r  = 1'b0;
  logic ret_r  = 1'b0;
  logic rclk_r = 1'b0;

  assign raw_o  = raw_r;
  assign ret_o  = ret_r;
  assign rclk_o = rclk_r;

  // fresh bits each cycle, clock toggles
  always @(negedge ref_clk_i) begin
    raw_r  <= 1'($urandom);
    ret_r  <= 1'($urandom);
    rclk_r <= ~rclk_r;
  end
endmodule : src_far_model

/* bench/src_reclock_ctrl_test.sv */
/*
  bench: pin level cases, settle, then compare outputs.
  assumes the far model and the checker are compiled first.
*/
`timescale 1ns/1ps

module src_reclock_ctrl_test;
  logic               ref_clk_i = 1'b0;
  logic               nrst_i    = 1'b0;
  logic               tie       = 1'b0;
  logic               mute_t    = 1'b0;
  src_pkg::src_ctrl_t ctrl      = 5'h02;
  src_pkg::src_loop_t loop      = '0;
  src_pkg::src_ctrl_t pin;
  logic [1:0]         pri, sec, rmode;
  logic               lock, byp, inv, raw, ret, rclk, pr, pt, pc;
  int                 err_total = 0;
  int                 checks    = 0;
  logic [4:0] tc [0:11] = '{5'h02, 5'h0A, 5'h12, 5'h0A, 5'h02, 5'h02, 5'h06, 5'h03, 5'h07, 5'h00, 5'h1A, 5'h02};
  logic [4:0] tl [0:11] = '{5'h19, 5'h19, 5'h1D, 5'h1D, 5'h1E, 5'h1F, 5'h19, 5'h19, 5'h19, 5'h19, 5'h19, 5'h09};

  always #5 ref_clk_i = ~ref_clk_i;
  // mute pin wired back to lock
  always @(negedge ref_clk_i) mute_t <= lock;
  assign pin = tie ? {ctrl.rate_sel, ctrl.bypass_force, mute_t, ctrl.second_out_clock_select} : ctrl;

  src_far_model far (.ref_clk_i(ref_clk_i), .raw_o(raw), .ret_o(ret), .rclk_o(rclk));
  src_reclock_ctrl DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ctrl_i(pin), .loop_i(loop),
    .serial_in_pair_i(raw), .retimed_data_i(ret), .recovered_clk_i(rclk), .primary_serial_out_o(pri),
    .second_out_clock_or_data_o(sec), .lock_indicator_o(lock), .bypass_active_o(byp),
    .second_clock_invalid_o(inv), .rate_mode_o(rmode));

  // ========================================
  // expectations and compares
  function automatic logic acc(logic [1:0] s, logic [2:0] m);
    return (m inside {[3'h1:3'h5]}) && (s == 2'h0 || (s == 2'h1 && m == 3'h1) || (s == 2'h2 && m != 3'h1));
  endfunction : acc

  task automatic chk(string nm, logic [1:0] e, logic [1:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic run(src_pkg::src_ctrl_t c, src_pkg::src_loop_t l, logic t);
    logic       lk, m, iv;
    logic [1:0] ep;
    @(negedge ref_clk_i);
    ctrl = c;
    loop = l;
    tie  = t;
    repeat (45) @(negedge ref_clk_i);
    lk = l.activity & l.pll_locked & ~c.bypass_force & acc(c.rate_sel, l.meas_rate);
    m  = t ? lk : c.mute_n;
    chk("lock", {1'b0, lk}, {1'b0, lock});
    chk("bypass", {1'b0, ~lk}, {1'b0, byp});
    chk("rate", c.rate_sel, rmode);
    // clock unusable only when the selected mode refuses the measured rate
    iv = c.second_out_clock_select & ~c.bypass_force & ~acc(c.rate_sel, l.meas_rate);
    chk("invalid", {1'b0, iv}, {1'b0, inv});
    repeat (4) begin
      // outputs launched at this edge carry the bits still standing now
      @(posedge ref_clk_i);
      #1;
      pr = raw;
      pt = ret;
      pc = rclk;
      ep = (m && (lk ? pt : pr)) ? 2'h2 : 2'h1;
      chk("primary", ep, pri);
      chk("second", c.second_out_clock_select ? ((m & lk) ? {pc, ~pc} : 2'h1) : ep, sec);
    end
  endtask : run

  // ========================================
  // main sequence
  initial begin
    void'($urandom(55324));
    repeat (3) @(negedge ref_clk_i);
    chk("reset", 2'h1, pri);
    nrst_i = 1'b1;
    loop   = 5'h19;
    repeat (30) @(negedge ref_clk_i);
    chk("early", 2'h0, {1'b0, lock});
    for (int i = 0; i < 12; i++) begin
      run(tc[i], tl[i], i >= 10);
    end
    run(5'h02, 5'h19, 1'b1);
    for (int i = 0; i < 20; i++) begin
      run(5'($urandom), 5'($urandom), 1'b0);
    end
    wrap_up();
  end
endmodule : src_reclock_ctrl_test
